//--- rtl/sadc_pkg.sv
/*
  Constants and types shared by the converter control block: register
  indices and byte addresses, field positions, reset values and timing.
  Assumes a 250 MHz clock that also stands for the oscillator.
*/
// What this block does
// - Clock select picks osc/2, /8, /32 or RC
// - Channel select codes route channels 0 to 4
// - Start bit begins conversion; hardware clears when done
// - Enable bit powers module; off draws nothing
// - Port config field sets analog, reference, digital pins
// - Completion loads result, clears start, sets flag
// - Reset leaves result register contents untouched
// - Each conversion lasts nine bit periods
// - Port reads show zero on analog pins
// - Selected channel converts even when pin digital
// - Clearing start aborts; result keeps old value
// - After abort wait two bit periods, then acquire
// - RC clock delays start by one instruction cycle
// - RC conversion in sleep completes, wakes or powers down
// - Sleep with other clocks aborts and powers down
// - Reset disables, aborts, makes all pins analog
// - Trigger starts conversion only while enabled
package sadc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RC_TAD_NS = 4000;
  localparam int RC_TAD_CLKS = RC_TAD_NS / CLK_PERIOD_NS;
  localparam int INSTR_CYC_CLKS = 4;
  localparam int TAD_DIV2_CLKS = 2;
  localparam int TAD_DIV8_CLKS = 8;
  localparam int TAD_DIV32_CLKS = 32;
  localparam int CONV_TADS = 9;
  localparam int HOLD_TADS = 2;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int IDX_PORT = 32'h05;
  localparam int IDX_RESULT = 32'h1e;
  localparam int IDX_CTRL_MAIN = 32'h1f;
  localparam int IDX_IRQ = 32'h20;
  localparam int IDX_PIN_CFG = 32'h9f;
  localparam logic [11:0] ADDR_PORT = 12'(IDX_PORT * 4);
  localparam logic [11:0] ADDR_RESULT = 12'(IDX_RESULT * 4);
  localparam logic [11:0] ADDR_CTRL_MAIN = 12'(IDX_CTRL_MAIN * 4);
  localparam logic [11:0] ADDR_IRQ = 12'(IDX_IRQ * 4);
  localparam logic [11:0] ADDR_PIN_CFG = 12'(IDX_PIN_CFG * 4);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CS_MSB = 7;
  localparam int CS_LSB = 6;
  localparam int CH_MSB = 5;
  localparam int CH_LSB = 3;
  localparam int GO_BIT = 2;
  localparam int ON_BIT = 0;
  localparam int CFG_MSB = 2;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT = 1;
  localparam logic [1:0] CS_RC = 2'h3;
  localparam logic [7:0] CTRL_MAIN_RST = 8'h00;
  localparam logic [2:0] PIN_CFG_RST = 3'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [5:0] MASK_ALL = 6'h2f;
  localparam logic [5:0] MASK_PART = 6'h0b;
  localparam logic [5:0] MASK_NONE = 6'h00;

  typedef enum logic [1:0] {S_IDLE, S_DELAY, S_CONV, S_HOLD} sadc_fsm_t;
endpackage

//--- rtl/sadc_sar.sv
/*
  Successive-approximation sequencer: one setup period, then eight bit
  decisions on the bit-period enable. Assumes the comparator input is a
  settled digital level when each enable pulse arrives.
*/
module sadc_sar (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tad_tick,
  input wire logic start,
  input wire logic abort,
  input wire logic cmp_in,
  output logic done,
  output logic [7:0] result,
  output logic [7:0] dac_code
);
  typedef struct packed {
    logic run;
    logic [3:0] step;
    logic [7:0] trial;
    logic [7:0] res;
    logic done;
  } sadc_sar_st_t;

  sadc_sar_st_t st_r;
  sadc_sar_st_t st_nxt;
  logic [3:0] tk_r;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [2:0] b;
    b = 3'(4'd8 - st_r.step);
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (abort) begin
      st_nxt.run = 1'b0;
    end else if (start) begin
      st_nxt.run = 1'b1;
      st_nxt.step = 4'h0;
      st_nxt.trial = 8'h00;
    end else if (st_r.run && tad_tick) begin
      if (st_r.step == 4'h0) begin
        st_nxt.trial = 8'h80;
      end else begin
        if (!cmp_in) begin
          st_nxt.trial[b] = 1'b0;
        end
        if (b != 3'h0) begin
          st_nxt.trial[3'(b - 3'h1)] = 1'b1;
        end
      end
      if (st_r.step == 4'(sadc_pkg::CONV_TADS - 1)) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.res = st_nxt.trial;
      end
      st_nxt.step = 4'(st_r.step + 4'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
  assign result = st_r.res;
  assign dac_code = st_r.trial;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || start) begin
      tk_r <= 4'h0;
    end else if (st_r.run && tad_tick) begin
      tk_r <= 4'(tk_r + 4'h1);
    end
  end

  sar_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> tk_r == 4'(sadc_pkg::CONV_TADS))
    else $error("conversion length wrong");

  sar_msb_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.run && tad_tick && st_r.step == 4'h0 && !abort && !start)
      |=> dac_code == 8'h80)
    else $error("first trial not msb");
endmodule

//--- rtl/sadc_top.sv
/*
  Converter control block: register file on AXI4-Lite, bit-period divider,
  start, abort, sleep and trigger handling, result and completion flag.
  Assumes the comparator, multiplexer and pins live outside; all inputs
  are synchronous to clk.
*/
// The AXI4-Lite register port is this design's own decision.
module sadc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] port_pin_in,
  input wire logic cmp_in,
  input wire logic trig_in,
  input wire logic sleep_in,
  output logic [2:0] channel_select,
  output logic [7:0] dac_code,
  output logic sample_en,
  output logic analog_power,
  output logic vref_ext,
  output logic [5:0] analog_pin_mask,
  output logic converter_irq_flag,
  output logic converter_irq_enable,
  output logic wake_req
);
  typedef struct packed {
    sadc_pkg::sadc_fsm_t fsm;
    logic [1:0] cs;
    logic [2:0] chs;
    logic go;
    logic on;
    logic [2:0] cfg;
    logic [7:0] result;
    logic flag;
    logic irq_en;
    logic [10:0] cnt;
    logic [1:0] hold_n;
    logic pwr;
    logic wake;
    logic aw_got;
    logic [11:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sadc_st_t;

  sadc_st_t st_r;
  sadc_st_t st_nxt;
  logic tad_tick;
  logic sw_start;
  logic conv_kill;
  logic seq_start;
  logic seq_done;
  logic [7:0] seq_res;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [10:0] tad_clks(input logic [1:0] cs);
    case (cs)
      2'h0: tad_clks = 11'(sadc_pkg::TAD_DIV2_CLKS);
      2'h1: tad_clks = 11'(sadc_pkg::TAD_DIV8_CLKS);
      2'h2: tad_clks = 11'(sadc_pkg::TAD_DIV32_CLKS);
      default: tad_clks = 11'(sadc_pkg::RC_TAD_CLKS);
    endcase
  endfunction

  // VREF pin counts as analog: it is not a digital input either
  function automatic logic [5:0] pin_mask(input logic [2:0] cfg);
    case (cfg[2:1])
      2'h2: pin_mask = sadc_pkg::MASK_PART;
      2'h3: pin_mask = sadc_pkg::MASK_NONE;
      default: pin_mask = sadc_pkg::MASK_ALL;
    endcase
  endfunction

  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic busy;
    logic ws;
    logic [11:0] wa;
    logic [7:0] wd;
    logic [10:0] per;
    aw_hs = s_axi_awvalid && s_axi_awready;
    w_hs = s_axi_wvalid && s_axi_wready;
    do_wr = (aw_hs || st_r.aw_got) && (w_hs || st_r.w_got);
    busy = (st_r.fsm == sadc_pkg::S_DELAY) || (st_r.fsm == sadc_pkg::S_CONV);
    wa = aw_hs ? s_axi_awaddr : st_r.awaddr;
    wd = w_hs ? s_axi_wdata[7:0] : st_r.wdata;
    ws = w_hs ? s_axi_wstrb[0] : st_r.wstrb0;
    per = tad_clks(st_r.cs);
    st_nxt = st_r;
    st_nxt.wake = 1'b0;
    sw_start = 1'b0;
    conv_kill = 1'b0;
    seq_start = 1'b0;
    tad_tick = ((st_r.fsm == sadc_pkg::S_CONV) || (st_r.fsm == sadc_pkg::S_HOLD))
      && (st_r.cnt == 11'(per - 11'h1));
    // Write channels, taken in either order
    if (aw_hs) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata[7:0];
      st_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = sadc_pkg::RESP_OKAY;
      case ({wa[11:2], 2'h0})
        sadc_pkg::ADDR_CTRL_MAIN: begin
          if (ws) begin
            st_nxt.cs = wd[sadc_pkg::CS_MSB:sadc_pkg::CS_LSB];
            st_nxt.chs = wd[sadc_pkg::CH_MSB:sadc_pkg::CH_LSB];
            st_nxt.on = wd[sadc_pkg::ON_BIT];
            if (!wd[sadc_pkg::ON_BIT]) begin
              st_nxt.go = 1'b0;
              conv_kill = busy;
            end else if (wd[sadc_pkg::GO_BIT] && st_r.on
                         && st_r.fsm == sadc_pkg::S_IDLE) begin
              sw_start = 1'b1;
            end else if (!wd[sadc_pkg::GO_BIT]) begin
              st_nxt.go = 1'b0;
              conv_kill = busy;
            end
          end
        end
        sadc_pkg::ADDR_PIN_CFG: if (ws) st_nxt.cfg = wd[sadc_pkg::CFG_MSB:0];
        sadc_pkg::ADDR_RESULT: if (ws) st_nxt.result = wd;
        sadc_pkg::ADDR_IRQ: begin
          if (ws) begin
            st_nxt.flag = wd[sadc_pkg::FLAG_BIT];
            st_nxt.irq_en = wd[sadc_pkg::IEN_BIT];
          end
        end
        sadc_pkg::ADDR_PORT: ; // Read-only: a write only answers
        default: st_nxt.bresp = sadc_pkg::RESP_SLVERR;
      endcase
    end
    // Read channel
    if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = sadc_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h0;
      case ({s_axi_araddr[11:2], 2'h0})
        sadc_pkg::ADDR_CTRL_MAIN:
          st_nxt.rdata[7:0] = {st_r.cs, st_r.chs, st_r.go, 1'b0, st_r.on};
        sadc_pkg::ADDR_PIN_CFG: st_nxt.rdata[2:0] = st_r.cfg;
        sadc_pkg::ADDR_RESULT: st_nxt.rdata[7:0] = st_r.result;
        sadc_pkg::ADDR_IRQ: st_nxt.rdata[1:0] = {st_r.irq_en, st_r.flag};
        sadc_pkg::ADDR_PORT:
          st_nxt.rdata[5:0] = port_pin_in & ~pin_mask(st_r.cfg);
        default: st_nxt.rresp = sadc_pkg::RESP_SLVERR;
      endcase
    end
    // Trigger is dropped while disabled or already running
    if (trig_in && st_r.on && st_r.fsm == sadc_pkg::S_IDLE) sw_start = 1'b1;
    if (sleep_in && st_r.cs != sadc_pkg::CS_RC && busy) conv_kill = 1'b1;
    // A finished result beats an abort in the same cycle
    if (seq_done) begin
      st_nxt.result = seq_res;
      st_nxt.go = 1'b0;
      st_nxt.flag = 1'b1;
      st_nxt.fsm = sadc_pkg::S_IDLE;
      st_nxt.wake = sleep_in && st_r.irq_en;
      conv_kill = 1'b0;
      sw_start = 1'b0;
    end
    if (conv_kill) begin
      st_nxt.go = 1'b0;
      st_nxt.fsm = sadc_pkg::S_HOLD;
      st_nxt.cnt = 11'h0;
      st_nxt.hold_n = 2'h0;
    end else if (sw_start) begin
      st_nxt.go = 1'b1;
      st_nxt.cnt = 11'h0;
      if (st_r.cs == sadc_pkg::CS_RC) begin
        st_nxt.fsm = sadc_pkg::S_DELAY;
      end else begin
        st_nxt.fsm = sadc_pkg::S_CONV;
        seq_start = 1'b1;
      end
    end else begin
      case (st_r.fsm)
        sadc_pkg::S_DELAY: begin
          if (st_r.cnt == 11'(sadc_pkg::INSTR_CYC_CLKS - 1)) begin
            st_nxt.fsm = sadc_pkg::S_CONV;
            st_nxt.cnt = 11'h0;
            seq_start = 1'b1;
          end else begin
            st_nxt.cnt = 11'(st_r.cnt + 11'h1);
          end
        end
        sadc_pkg::S_CONV, sadc_pkg::S_HOLD: begin
          st_nxt.cnt = tad_tick ? 11'h0 : 11'(st_r.cnt + 11'h1);
          if (st_r.fsm == sadc_pkg::S_HOLD && tad_tick) begin
            if (st_r.hold_n == 2'(sadc_pkg::HOLD_TADS - 1)) begin
              st_nxt.fsm = sadc_pkg::S_IDLE;
            end else begin
              st_nxt.hold_n = 2'(st_r.hold_n + 2'h1);
            end
          end
        end
        default: ;
      endcase
    end
    // Idle in sleep, or any sleep off the RC clock, powers down
    st_nxt.pwr = st_nxt.on && !(sleep_in && (st_nxt.fsm == sadc_pkg::S_IDLE
      || st_nxt.cs != sadc_pkg::CS_RC));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.fsm <= sadc_pkg::S_IDLE;
      {st_r.cs, st_r.chs, st_r.go} <= sadc_pkg::CTRL_MAIN_RST[sadc_pkg::CS_MSB:sadc_pkg::GO_BIT];
      st_r.on <= sadc_pkg::CTRL_MAIN_RST[sadc_pkg::ON_BIT];
      st_r.cfg <= sadc_pkg::PIN_CFG_RST;
      {st_r.irq_en, st_r.flag} <= sadc_pkg::IRQ_RST;
      st_r.result <= st_r.result;
    end else begin
      st_r <= st_nxt;
    end
  end

  sadc_sar u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .tad_tick(tad_tick),
    .start(seq_start),
    .abort(conv_kill),
    .cmp_in(cmp_in),
    .done(seq_done),
    .result(seq_res),
    .dac_code(dac_code)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign channel_select = st_r.chs;
  assign analog_power = st_r.pwr;
  assign sample_en = st_r.pwr && st_r.fsm == sadc_pkg::S_IDLE;
  assign vref_ext = st_r.cfg[0] && st_r.cfg[2:1] != 2'h3;
  assign analog_pin_mask = pin_mask(st_r.cfg);
  assign converter_irq_flag = st_r.flag;
  assign converter_irq_enable = st_r.irq_en;
  assign wake_req = st_r.wake;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence rc_start_s;
    sw_start && !conv_kill && st_r.cs == sadc_pkg::CS_RC;
  endsequence
  sequence rc_wait_s;
    (st_r.fsm == sadc_pkg::S_DELAY && !conv_kill)[*4];
  endsequence
  done_load_a: assert property (
    seq_done |=> !st_r.go && st_r.flag && st_r.result == $past(seq_res)
      && st_r.fsm == sadc_pkg::S_IDLE)
    else $error("completion did not load result");
  go_start_a: assert property (
    (sw_start && !conv_kill && !seq_done) |=> st_r.go
      && st_r.fsm != sadc_pkg::S_IDLE)
    else $error("start did not set status");
  abort_keep_a: assert property (
    conv_kill |=> $stable(st_r.result) && !st_r.go
      && st_r.fsm == sadc_pkg::S_HOLD)
    else $error("abort changed result");
  hold_len_a: assert property (
    (st_r.fsm == sadc_pkg::S_HOLD ##1 st_r.fsm == sadc_pkg::S_IDLE)
      |-> $past(tad_tick) && $past(st_r.hold_n) == 2'h1)
    else $error("abort wait not two periods");
  rc_delay_a: assert property (
    rc_start_s ##1 rc_wait_s |=> st_r.fsm == sadc_pkg::S_CONV)
    else $error("rc start delay wrong");
  port_zero_a: assert property (
    (s_axi_arvalid && s_axi_arready
      && {s_axi_araddr[11:2], 2'h0} == sadc_pkg::ADDR_PORT)
      |=> (s_axi_rdata[5:0] & analog_pin_mask) == 6'h00)
    else $error("analog pin read not zero");
  trig_off_a: assert property (
    (trig_in && !st_r.on && st_r.fsm == sadc_pkg::S_IDLE
      && !(s_axi_awvalid || s_axi_wvalid || st_r.aw_got || st_r.w_got))
      |=> !st_r.go)
    else $error("trigger acted while disabled");
  sleep_abort_a: assert property (
    (sleep_in && st_r.cs != sadc_pkg::CS_RC && st_r.fsm == sadc_pkg::S_CONV
      && !seq_done) |=> !st_r.go && !analog_power && st_r.on == $past(st_r.on))
    else $error("sleep did not abort");
  off_power_a: assert property (
    !st_r.on |-> !analog_power)
    else $error("disabled module powered");
endmodule

//--- verification/sadc_afe_model.sv
/*
  Far-side model: channel mux and comparator.
  Assumes the bench supplies one 8-bit level per channel, channel 0 lowest.
*/
module sadc_afe_model (
  input wire logic clk,
  input wire logic [2:0] channel_select,
  input wire logic [7:0] dac_code,
  input wire logic analog_power,
  input wire logic [39:0] levels,
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0;
  logic [7:0] lvl;
  // Unpowered or unrouted: no fixed answer, so it flips
  always @(posedge clk) tog <= ~tog;
  assign lvl = levels[channel_select * 8 +: 8];
  // Pin mode is ignored on purpose
  assign cmp_in = (analog_power && channel_select < 3'h5) ? (lvl >= dac_code) : tog;
endmodule

//--- verification/sar_adc_control_tb.sv
/*
  Self-checking bench for the converter control block over AXI4-Lite.
  Assumes the design package and the far-side comparator model.
*/
module sar_adc_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, cmp_in, trig_in, sleep_in, sample_en, analog_power, vref_ext;
  logic converter_irq_flag, converter_irq_enable, wake_req;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] port_pin_in, analog_pin_mask, m;
  logic [2:0] channel_select;
  logic [7:0] dac_code;
  logic [39:0] levels = 40'hc3_01_fe_80_5a;
  int bad_count = 0;
  int cmp_count = 0;
  int n;
  bit woke = 1'b0;

  sadc_top dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_pin_in, .cmp_in,
    .trig_in, .sleep_in, .channel_select, .dac_code, .sample_en, .analog_power,
    .vref_ext, .analog_pin_mask, .converter_irq_flag, .converter_irq_enable, .wake_req);
  sadc_afe_model afe (.clk, .channel_select, .dac_code, .analog_power, .levels, .cmp_in);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Wake is a one-cycle pulse, so latch it
  always @(posedge clk) if (wake_req === 1'b1) woke <= 1'b1;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er = sadc_pkg::RESP_OKAY);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 50);
    check("bresp", s_axi_bresp, er);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                     input logic [1:0] er = sadc_pkg::RESP_OKAY);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 50);
    check($sformatf("rdata %h", a), s_axi_rdata, exp);
    check("rresp", s_axi_rresp, er);
  endtask
  task automatic wait_flag(output int c);
    c = 0;
    while (converter_irq_flag !== 1'b1 && c < 12000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  task automatic conv(input logic [1:0] cs, input logic [2:0] ch, input logic slp);
    int p;
    sleep_in <= 1'b0; // Software only writes while awake
    p = (cs == 2'h3) ? 1000 : (2 << (2 * cs));
    wr(sadc_pkg::ADDR_CTRL_MAIN, {cs, ch, 3'h1}); // Enable alone first
    check("power", analog_power, 1'b1);
    repeat (4000) @(posedge clk); // Acquisition wait
    wr(sadc_pkg::ADDR_CTRL_MAIN, {cs, ch, 3'h5});
    sleep_in <= slp;
    check("channel", channel_select, ch);
    wait_flag(n);
    p = 9 * p + ((cs == 2'h3) ? sadc_pkg::INSTR_CYC_CLKS : 0);
    check("conv time", n >= p && n <= p + 1, 1'b1);
    rdc(sadc_pkg::ADDR_RESULT, levels[ch * 8 +: 8]);
    rdc(sadc_pkg::ADDR_CTRL_MAIN, {cs, ch, 3'h1});
    wr(sadc_pkg::ADDR_IRQ, 8'h0);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, s_axi_wstrb, port_pin_in} = {1'b1, 4'h1, 6'h3f};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, trig_in, sleep_in} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(sadc_pkg::ADDR_CTRL_MAIN, 0);
    rdc(sadc_pkg::ADDR_PIN_CFG, 0);
    check("off", analog_power, 1'b0);
    rdc(12'h004, 0, sadc_pkg::RESP_SLVERR);
    wr(12'h004, 8'hff, sadc_pkg::RESP_SLVERR);
    for (int c = 0; c < 8; c++) begin
      wr(sadc_pkg::ADDR_PIN_CFG, 8'(c));
      m = (c[2:1] == 2'h3) ? 6'h00 : (c[2] ? 6'h0b : 6'h2f);
      check("pin mask", analog_pin_mask, m);
      check("vref", vref_ext, c[0] && c[2:1] != 2'h3);
      rdc(sadc_pkg::ADDR_PORT, {26'h0, 6'h3f & ~m});
    end
    // Fast selects miss the period window at this clock; they only test counts
    for (int i = 0; i < 5; i++) conv(2'(i % 3), 3'(i), 1'b0); // All pins digital
    wr(sadc_pkg::ADDR_IRQ, 8'h2);
    check("irq en", converter_irq_enable, 1'b1);
    conv(2'h3, 3'h4, 1'b1); // RC period fits the window
    check("wake", woke, 1'b1);
    conv(2'h3, 3'h1, 1'b1);
    check("sleep off", analog_power, 1'b0);
    sleep_in <= 1'b0;
    wr(sadc_pkg::ADDR_RESULT, 8'ha5);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h81);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h85);
    repeat (40) @(posedge clk);
    rdc(sadc_pkg::ADDR_CTRL_MAIN, 8'h85);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h81);
    n = 0;
    while (sample_en !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("abort wait", n >= 32 && n <= 66, 1'b1);
    repeat (400) @(posedge clk);
    check("abort flag", converter_irq_flag, 1'b0);
    rdc(sadc_pkg::ADDR_RESULT, 8'ha5);
    s_axi_wstrb <= 4'h0;
    wr(sadc_pkg::ADDR_RESULT, 8'h3c);
    s_axi_wstrb <= 4'h1;
    rdc(sadc_pkg::ADDR_RESULT, 8'ha5);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h45);
    repeat (20) @(posedge clk);
    sleep_in <= 1'b1;
    repeat (10) @(posedge clk);
    check("sleep power", analog_power, 1'b0);
    rdc(sadc_pkg::ADDR_CTRL_MAIN, 8'h41);
    sleep_in <= 1'b0;
    repeat (400) @(posedge clk);
    rdc(sadc_pkg::ADDR_RESULT, 8'ha5);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h10);
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    rdc(sadc_pkg::ADDR_CTRL_MAIN, 8'h10);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h11);
    repeat (4000) @(posedge clk);
    trig_in <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    rdc(sadc_pkg::ADDR_CTRL_MAIN, 8'h15);
    wait_flag(n);
    rdc(sadc_pkg::ADDR_RESULT, levels[23:16]);
    wr(sadc_pkg::ADDR_IRQ, 8'h0);
    wr(sadc_pkg::ADDR_CTRL_MAIN, 8'h95);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdc(sadc_pkg::ADDR_CTRL_MAIN, 0);
    check("rst power", analog_power, 1'b0);
    check("rst mask", analog_pin_mask, 6'h2f);
    rdc(sadc_pkg::ADDR_RESULT, levels[23:16]);
    repeat (400) @(posedge clk);
    check("rst flag", converter_irq_flag, 1'b0);
    tally_and_finish();
  end
endmodule
